// file: hdl/rss_pkg.sv
package rss_pkg;

    // Register map (byte addresses on Wishbone)
    localparam logic [7:0] ADDR_POWER_CONTROL_STATUS = 8'h8E;
    localparam logic [7:0] ADDR_CONFIG               = 8'h90;
    localparam logic [7:0] ADDR_RESET_STATUS         = 8'h94;
    localparam logic [7:0] ADDR_RETAINED             = 8'h98;

    // power_control_status fields
    localparam int BIT_BROWNOUT_FLAG   = 0;
    localparam int BIT_POWERON_FLAG    = 1;
    localparam int BIT_OSC_SPEED       = 3;
    localparam logic OSC_SPEED_RESET   = 1'b1;

    // Config register fields
    localparam int CFG_OSC_LSB         = 0;
    localparam int CFG_OSC_W           = 3;
    localparam int CFG_POWERUP_TIMER_DIS        = 3;
    localparam int CFG_BOD_EN          = 4;
    localparam int CFG_CLOCK_OUT_PIN_EN       = 5;
    localparam logic [7:0] CFG_RESET   = 8'h00;

    // Reset status register fields
    localparam int ST_TIMEOUT          = 0;
    localparam int ST_POWERDOWN        = 1;
    localparam int ST_CHIP_RESET       = 2;

    // Oscillator modes
    typedef enum logic [2:0] {
        OSC_LP   = 3'h0,
        OSC_XT   = 3'h1,
        OSC_HS   = 3'h2,
        OSC_EC   = 3'h3,
        OSC_INTERNAL_RC_OSC_MODE_IO  = 3'h4,
        OSC_INTERNAL_RC_OSC_MODE_CLK = 3'h5,
        OSC_ER_IO     = 3'h6,
        OSC_ER_CLK    = 3'h7
    } rss_osc_mode_t;

    typedef enum logic [2:0] {
        ST_POR   = 3'h0,
        ST_BOR   = 3'h1,
        ST_POWERUP_TIMER  = 3'h2,
        ST_OST   = 3'h3,
        ST_HOLD  = 3'h4,
        ST_RUN   = 3'h5
    } rss_state_t;

    // Timing
    localparam int  POWERUP_TIMER_MS          = 72;
    localparam int  RC_CLK_HZ        = 37000;
    localparam int  POWERUP_TIMER_RC_CYCLES   = (POWERUP_TIMER_MS * RC_CLK_HZ) / 1000;
    localparam int  OST_CYCLES       = 1024;
    localparam int  CLK_DIV          = 4;
    localparam int  MASTER_CLEAR_PIN_FILTER      = 4;
    localparam int  BOD_MIN_CYCLES   = 2;

    typedef struct packed {
        logic poweron_event;
        logic brownout_event;
        logic master_clear_pin_event;
        logic wdt_reset_event;
        logic wdt_wake_event;
    } rss_events_t;

endpackage

// file: hdl/rss_reset_startup_sequencer.sv
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rss_reset_startup_sequencer #(
    parameter int POWERUP_TIMER_CYCLES = rss_pkg::POWERUP_TIMER_RC_CYCLES,
    parameter int OST_COUNT   = rss_pkg::OST_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       vdd_rise_i,
    input  wire logic       brownout_low_i,
    input  wire logic       master_clear_pin_n_i,
    input  wire logic       wdt_timeout_i,
    input  wire logic       sleep_i,
    input  wire logic       rc_tick_i,
    input  wire logic       osc_in_tick_i,
    output logic            chip_reset_o,
    output logic            osc_speed_select_o,
    output logic            osc_out_pin_o,
    output logic            osc_out_pin_oe_n_o,
    output logic            wake_o
);

    localparam int PW = $clog2(POWERUP_TIMER_CYCLES + 1);
    localparam int OW = $clog2(OST_COUNT + 1);

    rss_pkg::rss_state_t state;
    rss_pkg::rss_state_t next_state;
    rss_pkg::rss_events_t ev;

    logic [7:0]  cfg;
    logic [7:0]  retained;
    logic        brownout_flag;
    logic        poweron_flag;
    logic        osc_speed_select;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic [PW-1:0] powerup_timer_cnt;
    logic [OW-1:0] ost_cnt;
    logic [2:0]  master_clear_pin_sync;
    logic [2:0]  bod_sync;
    logic [2:0]  vdd_sync;
    logic [2:0]  rct_sync;
    logic [2:0]  osct_sync;
    logic [$clog2(rss_pkg::MASTER_CLEAR_PIN_FILTER+1)-1:0] master_clear_pin_cnt;
    logic [$clog2(rss_pkg::BOD_MIN_CYCLES+1)-1:0] bod_cnt;
    logic        master_clear_pin_low;
    logic        bod_low;
    logic        rc_prev;
    logic        osc_prev;
    logic        rc_edge;
    logic        osc_edge;
    logic        vdd_ok;
    logic        ost_needed;
    logic        powerup_timer_needed;
    logic [1:0]  div_cnt;
    logic        clk_div4;
    logic        wdt_prev;
    logic        bus_req;
    rss_pkg::rss_osc_mode_t osc_mode;

    function automatic logic is_crystal(input rss_pkg::rss_osc_mode_t m);
        is_crystal = (m == rss_pkg::OSC_LP) || (m == rss_pkg::OSC_XT) ||
                     (m == rss_pkg::OSC_HS);
    endfunction

    function automatic logic is_rc(input rss_pkg::rss_osc_mode_t m);
        is_rc = (m == rss_pkg::OSC_ER_IO) || (m == rss_pkg::OSC_ER_CLK) ||
                (m == rss_pkg::OSC_INTERNAL_RC_OSC_MODE_IO) || (m == rss_pkg::OSC_INTERNAL_RC_OSC_MODE_CLK);
    endfunction

    assign osc_mode = rss_pkg::rss_osc_mode_t'(
        cfg[rss_pkg::CFG_OSC_LSB +: rss_pkg::CFG_OSC_W]);

    // Three-stage sync; decisions use stages two and three only
    always_ff @(posedge clk_i) begin
        master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin_n_i};
        bod_sync  <= {bod_sync[1:0], brownout_low_i};
        vdd_sync  <= {vdd_sync[1:0], vdd_rise_i};
        rct_sync  <= {rct_sync[1:0], rc_tick_i};
        osct_sync <= {osct_sync[1:0], osc_in_tick_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_prev  <= 1'b0;
            osc_prev <= 1'b0;
            vdd_ok   <= 1'b0;
        end else begin
            if (rct_sync[2] == rct_sync[1])
                rc_prev <= rct_sync[2];
            if (osct_sync[2] == osct_sync[1])
                osc_prev <= osct_sync[2];
            if (vdd_sync[2] == vdd_sync[1])
                vdd_ok <= vdd_sync[2];
        end
    end
    assign rc_edge  = (rct_sync[2] == rct_sync[1]) & rct_sync[2] & ~rc_prev;
    assign osc_edge = (osct_sync[2] == osct_sync[1]) & osct_sync[2] &
                      ~osc_prev;

    // Glitch filter: low must persist before it counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_clear_pin_cnt <= '0;
            master_clear_pin_low <= 1'b0;
        end else if (master_clear_pin_sync[2] == master_clear_pin_sync[1] && !master_clear_pin_sync[2]) begin
            if (master_clear_pin_cnt == ($bits(master_clear_pin_cnt))'(rss_pkg::MASTER_CLEAR_PIN_FILTER))
                master_clear_pin_low <= 1'b1;
            else
                master_clear_pin_cnt <= master_clear_pin_cnt + 1'b1;
        end else if (master_clear_pin_sync[2] == master_clear_pin_sync[1]) begin
            master_clear_pin_cnt <= '0;
            master_clear_pin_low <= 1'b0;
        end
    end

    // Short dips below threshold are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bod_cnt <= '0;
            bod_low <= 1'b0;
        end else if (bod_sync[2] == bod_sync[1] && bod_sync[2] &&
                     cfg[rss_pkg::CFG_BOD_EN]) begin
            if (bod_cnt == ($bits(bod_cnt))'(rss_pkg::BOD_MIN_CYCLES))
                bod_low <= 1'b1;
            else
                bod_cnt <= bod_cnt + 1'b1;
        end else if (bod_sync[2] == bod_sync[1]) begin
            bod_cnt <= '0;
            bod_low <= 1'b0;
        end
    end

    // Brown-out forces the power-up timer on regardless of the disable bit
    assign powerup_timer_needed = !cfg[rss_pkg::CFG_POWERUP_TIMER_DIS] ||
                         cfg[rss_pkg::CFG_BOD_EN];
    assign ost_needed  = is_crystal(osc_mode);

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wdt_prev <= 1'b0;
        else
            wdt_prev <= wdt_timeout_i;
    end

    always_comb begin
        ev = '0;
        ev.poweron_event   = (state == rss_pkg::ST_POR) && vdd_ok;
        ev.brownout_event  = bod_low && state != rss_pkg::ST_BOR &&
                             state != rss_pkg::ST_POR;
        ev.master_clear_pin_event      = master_clear_pin_low && state == rss_pkg::ST_RUN;
        ev.wdt_reset_event = wdt_timeout_i && !wdt_prev && !sleep_i &&
                             state == rss_pkg::ST_RUN;
        ev.wdt_wake_event  = wdt_timeout_i && !wdt_prev && sleep_i &&
                             state == rss_pkg::ST_RUN;
    end

    always_comb begin
        next_state = state;
        case (state)
            rss_pkg::ST_POR: begin
                if (vdd_ok)
                    next_state = bod_low ? rss_pkg::ST_BOR :
                                 powerup_timer_needed ? rss_pkg::ST_POWERUP_TIMER :
                                 ost_needed ? rss_pkg::ST_OST :
                                 rss_pkg::ST_HOLD;
            end
            rss_pkg::ST_BOR: begin
                if (!bod_low)
                    next_state = rss_pkg::ST_POWERUP_TIMER;
            end
            rss_pkg::ST_POWERUP_TIMER: begin
                if (bod_low)
                    next_state = rss_pkg::ST_BOR;
                else if (powerup_timer_cnt == '0)
                    next_state = ost_needed ? rss_pkg::ST_OST :
                                 rss_pkg::ST_HOLD;
            end
            rss_pkg::ST_OST: begin
                if (ost_cnt == '0)
                    next_state = rss_pkg::ST_HOLD;
            end
            rss_pkg::ST_HOLD: begin
                if (!master_clear_pin_low)
                    next_state = rss_pkg::ST_RUN;
            end
            rss_pkg::ST_RUN: begin
                if (ev.brownout_event)
                    next_state = rss_pkg::ST_BOR;
                else if (ev.wdt_wake_event && ost_needed)
                    next_state = rss_pkg::ST_OST;
                else if (ev.master_clear_pin_event || ev.wdt_reset_event)
                    next_state = rss_pkg::ST_HOLD;
            end
            default: next_state = rss_pkg::ST_POR;
        endcase
        if (!vdd_ok && state != rss_pkg::ST_POR &&
            state != rss_pkg::ST_RUN)
            next_state = rss_pkg::ST_POR;
    end

    // Supply falling alone never triggers POR once running
    always_ff @(posedge clk_i) begin
        if (rst_i)
            state <= rss_pkg::ST_POR;
        else
            state <= next_state;
    end

    // Counted on the internal RC tick, reloaded on each entry
    always_ff @(posedge clk_i) begin
        if (rst_i)
            powerup_timer_cnt <= PW'(POWERUP_TIMER_CYCLES);
        else if (state != rss_pkg::ST_POWERUP_TIMER)
            powerup_timer_cnt <= PW'(POWERUP_TIMER_CYCLES);
        else if (rc_edge && powerup_timer_cnt != '0)
            powerup_timer_cnt <= powerup_timer_cnt - 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            ost_cnt <= OW'(OST_COUNT);
        else if (state != rss_pkg::ST_OST)
            ost_cnt <= OW'(OST_COUNT);
        else if (osc_edge && ost_cnt != '0)
            ost_cnt <= ost_cnt - 1'b1;
    end

    // Wake from sleep resumes code, so the chip is not held in reset
    assign chip_reset_o = (state != rss_pkg::ST_RUN) && !(wake_o &&
        (state == rss_pkg::ST_OST ||
         (state == rss_pkg::ST_HOLD && !master_clear_pin_low)));

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wake_o <= 1'b0;
        else if (ev.wdt_wake_event)
            wake_o <= 1'b1;
        else if (state == rss_pkg::ST_RUN ||
                 state == rss_pkg::ST_POR)
            wake_o <= 1'b0;
    end

    // Cause flags; only hardware events move them, bus writes to the status register are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (ev.poweron_event) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (ev.wdt_wake_event) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
        end else if (ev.wdt_reset_event) begin
            timeout_flag   <= 1'b0;
        end else if (ev.master_clear_pin_event && sleep_i) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b0;
        end
    end

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brownout_flag <= 1'b0;
            poweron_flag  <= 1'b0;
        end else begin
            if (bus_req && wb_we_i && wb_sel_i[0] &&
                wb_adr_i == rss_pkg::ADDR_POWER_CONTROL_STATUS) begin
                brownout_flag <= wb_dat_i[rss_pkg::BIT_BROWNOUT_FLAG];
                poweron_flag  <= wb_dat_i[rss_pkg::BIT_POWERON_FLAG];
            end
            if (ev.brownout_event)
                brownout_flag <= 1'b0;
            if (ev.poweron_event)
                poweron_flag <= 1'b0;
        end
    end

    // Speed returns to its reset value on every reset event except watchdog wake; config resets only on rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_speed_select <= rss_pkg::OSC_SPEED_RESET;
            cfg              <= rss_pkg::CFG_RESET;
        end else if (ev.poweron_event || ev.brownout_event ||
                     ev.master_clear_pin_event || ev.wdt_reset_event) begin
            osc_speed_select <= rss_pkg::OSC_SPEED_RESET;
        end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == rss_pkg::ADDR_POWER_CONTROL_STATUS)
                osc_speed_select <= wb_dat_i[rss_pkg::BIT_OSC_SPEED];
            if (wb_adr_i == rss_pkg::ADDR_CONFIG)
                cfg <= wb_dat_i[7:0];
        end
    end

    // Retained scratch: no reset of any kind touches it
    always_ff @(posedge clk_i) begin
        if (bus_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == rss_pkg::ADDR_RETAINED)
            retained <= wb_dat_i[7:0];
    end

    // Speed select only acts in the RC modes; crystal modes run fast
    assign osc_speed_select_o = is_rc(osc_mode) ? osc_speed_select :
                                1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt  <= '0;
            clk_div4 <= 1'b0;
        end else if (div_cnt == 2'(rss_pkg::CLK_DIV / 2 - 1)) begin
            div_cnt  <= '0;
            clk_div4 <= ~clk_div4;
        end else begin
            div_cnt  <= div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_out_pin_o      <= 1'b0;
            osc_out_pin_oe_n_o <= 1'b1;
        end else begin
            osc_out_pin_o      <= clk_div4;
            osc_out_pin_oe_n_o <= !(osc_mode == rss_pkg::OSC_ER_CLK ||
                                    osc_mode == rss_pkg::OSC_INTERNAL_RC_OSC_MODE_CLK ||
                                    cfg[rss_pkg::CFG_CLOCK_OUT_PIN_EN]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= '0;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    rss_pkg::ADDR_POWER_CONTROL_STATUS: begin
                        wb_dat_o[rss_pkg::BIT_BROWNOUT_FLAG] <= brownout_flag;
                        wb_dat_o[rss_pkg::BIT_POWERON_FLAG]  <= poweron_flag;
                        wb_dat_o[rss_pkg::BIT_OSC_SPEED] <= osc_speed_select;
                    end
                    rss_pkg::ADDR_CONFIG:   wb_dat_o[7:0] <= cfg;
                    rss_pkg::ADDR_RESET_STATUS: begin
                        wb_dat_o[rss_pkg::ST_TIMEOUT]    <= timeout_flag;
                        wb_dat_o[rss_pkg::ST_POWERDOWN]  <= powerdown_flag;
                        wb_dat_o[rss_pkg::ST_CHIP_RESET] <= chip_reset_o;
                    end
                    rss_pkg::ADDR_RETAINED: wb_dat_o[7:0] <= retained;
                    default:                wb_dat_o <= '0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: verif/rss_reset_startup_sequencer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rss_reset_startup_sequencer_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        vdd_rise_i,
    input wire logic        brownout_low_i,
    input wire logic        master_clear_pin_n_i,
    input wire logic        wdt_timeout_i,
    input wire logic        sleep_i,
    input wire logic        rc_tick_i,
    input wire logic        osc_in_tick_i,
    input wire logic        chip_reset_o,
    input wire logic        osc_speed_select_o,
    input wire logic        osc_out_pin_o,
    input wire logic        osc_out_pin_oe_n_o,
    input wire logic        wake_o
);
    logic [7:0] cfg_q;
    wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Config mirror: only a bus write or rst_i moves it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 8'h00;
        end else if (take && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == rss_pkg::ADDR_CONFIG) begin
            cfg_q <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_latency: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_speed_forced: assert property (!cfg_q[2] |-> osc_speed_select_o)
        else $error("crystal mode not at full speed");
    a_pin_io: assert property ((cfg_q[2:0] == 3'h6 && !cfg_q[5]
        && $past(cfg_q[2:0]) == 3'h6) |-> osc_out_pin_oe_n_o)
        else $error("spare pin driven in io mode");
    a_clock_out_pin_div: assert property ((!osc_out_pin_oe_n_o) [*3]
        |-> osc_out_pin_o != $past(osc_out_pin_o, 2))
        else $error("clock out not divided by four");
    a_brownout_reset: assert property ((cfg_q[4] && brownout_low_i) [*8]
        |=> chip_reset_o)
        else $error("long dip did not reset");
    a_glitch_ignored: assert property ((!chip_reset_o && !brownout_low_i
        && $fell(master_clear_pin_n_i)) ##1 master_clear_pin_n_i
        |=> (!chip_reset_o) [*6])
        else $error("short pin pulse caused reset");
    a_master_clear_pin_reset: assert property ((!master_clear_pin_n_i) [*8]
        |=> ##1 chip_reset_o)
        else $error("held pin did not reset");
    a_wdt_reset: assert property (($rose(wdt_timeout_i) && !sleep_i
        && !chip_reset_o) |-> ##[1:4] chip_reset_o)
        else $error("watchdog did not reset");
    a_wake_runs: assert property (wake_o |-> !chip_reset_o)
        else $error("reset held during wake start-up");
endmodule
bind rss_reset_startup_sequencer rss_reset_startup_sequencer_asserts u_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .vdd_rise_i(vdd_rise_i), .brownout_low_i(brownout_low_i),
    .master_clear_pin_n_i(master_clear_pin_n_i),
    .wdt_timeout_i(wdt_timeout_i), .sleep_i(sleep_i),
    .rc_tick_i(rc_tick_i), .osc_in_tick_i(osc_in_tick_i),
    .chip_reset_o(chip_reset_o), .osc_speed_select_o(osc_speed_select_o),
    .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_n_o(osc_out_pin_oe_n_o),
    .wake_o(wake_o));
`default_nettype wire

// file: verif/rss_reset_startup_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module rss_reset_startup_sequencer_test;
    typedef struct {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [31:0] exp;
        logic [31:0] msk;
    } rss_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic        sleep = 1'b0;
    logic        wdt = 1'b0;
    logic        supply_on = 1'b0;
    logic        dip = 1'b0;
    logic        master_clear_pin_low = 1'b0;
    wire  [31:0] rdat;
    wire         ack, vdd, blow, master_clear_pin_n, rc, osc;
    wire         chip_reset, speed, pin, pin_oe_n, wake;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n;
    logic [31:0] rd;
    rss_row_t    rows [13] = '{
        '{1'h0, 8'h94, 32'h0, 32'h3, 32'hFFFFFFFF},
        '{1'h0, 8'h8E, 32'h0, 32'h8, 32'hFFFFFF0A},
        '{1'h1, 8'h98, 32'h5A, 32'h0, 32'h0},
        '{1'h0, 8'h98, 32'h0, 32'h5A, 32'hFFFFFFFF},
        '{1'h1, 8'h8E, 32'h0B, 32'h0, 32'h0},
        '{1'h0, 8'h8E, 32'h0, 32'h0B, 32'hFFFFFF0B},
        '{1'h0, 8'hA0, 32'h0, 32'h0, 32'hFFFFFFFF},
        '{1'h1, 8'h94, 32'hFF, 32'h0, 32'h0},
        '{1'h0, 8'h94, 32'h0, 32'h3, 32'hFFFFFFFF},
        '{1'h1, 8'h90, 32'h06, 32'h0, 32'h0},
        '{1'h0, 8'h90, 32'h0, 32'h06, 32'hFFFFFF3F},
        '{1'h1, 8'hA0, 32'h77, 32'h0, 32'h0},
        '{1'h0, 8'hA0, 32'h0, 32'h0, 32'hFFFFFFFF}};
    always #25 clk = ~clk;
    rss_supply_model u_rss_supply_model (.clk_i(clk), .supply_on_i(supply_on),
        .dip_i(dip), .master_clear_pin_low_i(master_clear_pin_low), .vdd_rise_o(vdd),
        .brownout_low_o(blow), .master_clear_pin_n_o(master_clear_pin_n),
        .rc_tick_o(rc), .osc_in_tick_o(osc));
    rss_reset_startup_sequencer #(.POWERUP_TIMER_CYCLES(4), .OST_COUNT(8))
        u_rss_reset_startup_sequencer (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .vdd_rise_i(vdd), .brownout_low_i(blow), .master_clear_pin_n_i(master_clear_pin_n),
        .wdt_timeout_i(wdt), .sleep_i(sleep), .rc_tick_i(rc),
        .osc_in_tick_i(osc), .chip_reset_o(chip_reset),
        .osc_speed_select_o(speed), .osc_out_pin_o(pin),
        .osc_out_pin_oe_n_o(pin_oe_n), .wake_o(wake));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Entered and left just after a rising edge; ack sampled at the edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        check("ack", 32'(ack), 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_for(input logic on_wake, input logic lvl, input int lim);
        n = 0;
        while ((on_wake ? wake : chip_reset) !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pin_low(input int len);
        master_clear_pin_low <= 1'b1;
        repeat (len) @(posedge clk);
        master_clear_pin_low <= 1'b0;
        wait_for(1'b0, 1'b0, 40);
        check("master_clear_pin_release", 32'(n <= 12), 32'h1);
    endtask
    task automatic status(input logic [31:0] exp);
        bus(1'b0, 8'h94, 32'h0);
        check("status", rd, exp);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        check("por_hold", 32'(chip_reset), 32'h1);
        supply_on <= 1'b1;
        wait_for(1'b0, 1'b0, 200);
        check("por_delay", 32'(n >= 46 && n <= 90), 32'h1);
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) check($sformatf("row%0d", i), rd & rows[i].msk,
                                   rows[i].exp);
        end
        bus(1'b1, 8'h8E, 32'h03);
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, 8'h90, (m == 5 || m == 7) ? 32'h20 + m : 32'(m));
            repeat (2) @(posedge clk);
            check("speed", 32'(speed), 32'(m < 4));
            check("pin_oe_n", 32'(pin_oe_n), 32'(m != 5 && m != 7));
            if (m == 7) begin
                rd = 32'(pin);
                repeat (2) @(posedge clk);
                check("clock_out_pin", 32'(pin), 32'(!rd[0]));
            end
        end
        bus(1'b1, 8'h8E, 32'h0B);
        check("speed_bit", 32'(speed), 32'h1);
        bus(1'b1, 8'h90, 32'h06);
        master_clear_pin_low <= 1'b1;
        @(posedge clk);
        master_clear_pin_low <= 1'b0;
        repeat (10) @(posedge clk);
        check("glitch", 32'(chip_reset), 32'h0);
        pin_low(10);
        status(32'h3);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        repeat (3) @(posedge clk);
        wait_for(1'b0, 1'b0, 40);
        status(32'h2);
        bus(1'b1, 8'h90, 32'h01);
        sleep <= 1'b1;
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        wait_for(1'b1, 1'b1, 10);
        wait_for(1'b1, 1'b0, 80);
        check("wake_len", 32'(n >= 28 && n <= 60), 32'h1);
        sleep <= 1'b0;
        status(32'h0);
        bus(1'b0, 8'h8E, 32'h0);
        check("wake_keep", rd & 32'hFFFFFF0B, 32'h0B);
        sleep <= 1'b1;
        pin_low(10);
        sleep <= 1'b0;
        status(32'h1);
        bus(1'b0, 8'h98, 32'h0);
        check("retained", rd, 32'h5A);
        bus(1'b1, 8'h90, 32'h16);
        dip <= 1'b1;
        @(posedge clk);
        dip <= 1'b0;
        repeat (8) @(posedge clk);
        check("short_dip", 32'(chip_reset), 32'h0);
        for (int r = 0; r < 2; r++) begin
            dip <= 1'b1;
            repeat (12) @(posedge clk);
            check("dip_hold", 32'(chip_reset), 32'h1);
            dip <= 1'b0;
            repeat (8) @(posedge clk);
        end
        wait_for(1'b0, 1'b0, 100);
        check("powerup_timer_restart", 32'(n >= 12 && n <= 60), 32'h1);
        bus(1'b0, 8'h8E, 32'h0);
        check("bod_flag", rd & 32'h3, 32'h2);
        conclude();
    end
endmodule
`default_nettype wire

// file: verif/rss_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module rss_supply_model (
    input  wire logic clk_i,
    input  wire logic supply_on_i,
    input  wire logic dip_i,
    input  wire logic master_clear_pin_low_i,
    output wire logic vdd_rise_o,
    output wire logic brownout_low_o,
    output wire logic master_clear_pin_n_o,
    output wire logic rc_tick_o,
    output wire logic osc_in_tick_o
);
    logic [2:0] rc_q = 3'h0;
    logic [1:0] osc_q = 2'h0;
    // Detector reads low supply until power is up; pin has a pull-up
    assign vdd_rise_o = supply_on_i;
    assign brownout_low_o = dip_i || !supply_on_i;
    assign master_clear_pin_n_o = !master_clear_pin_low_i;
    // Both oscillators run free: RC period 6 cycles, crystal 4 cycles
    always @(posedge clk_i) begin
        rc_q <= (rc_q == 3'h5) ? 3'h0 : rc_q + 3'h1;
        osc_q <= osc_q + 2'h1;
    end
    assign rc_tick_o = (rc_q < 3'h3);
    assign osc_in_tick_o = osc_q[1];
endmodule
`default_nettype wire
